// ---- hw/timers_pkg.sv ----
package timers_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // structure
    localparam int NUM_CH   = 5;
    localparam int XTAL_CH  = 4;
    localparam int CNT_W    = 32;
    localparam int PRE_W    = 8;
    localparam int NUM_CMP  = 4;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and step constants
    localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
    localparam logic [PRE_W-1:0] PRE_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
    localparam logic [PRE_W-1:0] PRE_ONE = 8'h01;

    ////////////////////////////////////////////////////////////////////////////
    // configuration carriers
    typedef struct packed {
        logic enable;
        logic irq_en;
        logic trig_en;
    } tick_cfg_t;

    typedef struct packed {
        logic             enable;
        logic             debug_freeze;
        logic [PRE_W-1:0] prescale;
    } monitor_cfg_t;

endpackage

// ---- hw/task_monitor_timer.sv ----
`timescale 1ns/10ps
module task_monitor_timer #(
    parameter int CNT_W   = timers_pkg::CNT_W,
    parameter int PRE_W   = timers_pkg::PRE_W,
    parameter int NUM_CMP = timers_pkg::NUM_CMP
) (
    // clock and reset
    input  wire logic                            clk_sys_i,
    input  wire logic                            rst_i,
    // configuration
    input  wire timers_pkg::monitor_cfg_t        cfg_i,
    input  wire logic [NUM_CMP-1:0][CNT_W-1:0]   cmp_val_i,
    input  wire logic [NUM_CMP-1:0]              cmp_en_i,
    input  wire logic [NUM_CMP-1:0]              cmp_ack_i,
    // system state
    input  wire logic                            debug_mode_i,
    input  wire logic                            stop_mode_i,
    // status
    output logic      [CNT_W-1:0]                count_o,
    output logic      [NUM_CMP-1:0]              cmp_irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // prescaler and up counter
    logic [PRE_W-1:0]   pre;
    logic [PRE_W-1:0]   next_pre;
    logic [CNT_W-1:0]   count;
    logic [CNT_W-1:0]   next_count;
    logic               frozen;
    logic               step;

    assign frozen = stop_mode_i | (debug_mode_i & cfg_i.debug_freeze);
    assign step   = cfg_i.enable & ~frozen & (pre == cfg_i.prescale);

    always_comb begin
        next_pre   = pre;
        next_count = count;
        if (cfg_i.enable && !frozen) begin
            if (step) begin
                next_pre   = timers_pkg::PRE_RST;
                next_count = count + timers_pkg::CNT_ONE;
            end else begin
                next_pre = pre + timers_pkg::PRE_ONE;
            end
        end else if (!cfg_i.enable) begin
            next_pre = timers_pkg::PRE_RST;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pre   <= timers_pkg::PRE_RST;
            count <= timers_pkg::CNT_RST;
        end else begin
            pre   <= next_pre;
            count <= next_count;
        end
    end

    assign count_o = count;

    ////////////////////////////////////////////////////////////////////////////
    // compare channels
    logic [NUM_CMP-1:0] flag;
    logic [NUM_CMP-1:0] next_flag;

    // counter moves past the compare value on this step
    always_comb begin
        for (int k = 0; k < NUM_CMP; k++) begin
            next_flag[k] = flag[k] & ~cmp_ack_i[k];
            if (step && cmp_en_i[k] && count == cmp_val_i[k]) begin
                next_flag[k] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            flag <= '0;
        end else begin
            flag <= next_flag;
        end
    end

    assign cmp_irq_o = flag;

endmodule

// ---- hw/periodic_and_task_timers.sv ----
`timescale 1ns/10ps
module periodic_and_task_timers #(
    parameter int NUM_CH  = timers_pkg::NUM_CH,
    parameter int XTAL_CH = timers_pkg::XTAL_CH,
    parameter int CNT_W   = timers_pkg::CNT_W,
    parameter int NUM_CMP = timers_pkg::NUM_CMP
) (
    // clock and reset
    input  wire logic                            clk_sys_i,
    input  wire logic                            rst_i,
    // crystal clock, sampled as a level
    input  wire logic                            xtal_clk_i,
    // system state
    input  wire logic                            stop_mode_i,
    input  wire logic                            debug_mode_i,
    // tick timer configuration
    input  wire timers_pkg::tick_cfg_t [NUM_CH-1:0] ch_cfg_i,
    input  wire logic [NUM_CH-1:0][CNT_W-1:0]    ch_load_i,
    input  wire logic [NUM_CH-1:0]               ch_ack_i,
    // task monitor configuration
    input  wire timers_pkg::monitor_cfg_t        mon_cfg_i,
    input  wire logic [NUM_CMP-1:0][CNT_W-1:0]   cmp_val_i,
    input  wire logic [NUM_CMP-1:0]              cmp_en_i,
    input  wire logic [NUM_CMP-1:0]              cmp_ack_i,
    // tick timer outputs
    output logic      [NUM_CH-1:0]               ch_irq_o,
    output logic      [NUM_CH-1:0]               ch_trig_o,
    output logic      [NUM_CH-1:0][CNT_W-1:0]    ch_count_o,
    output logic                                 sysclk_restart_o,
    // task monitor outputs
    output logic      [CNT_W-1:0]                mon_count_o,
    output logic      [NUM_CMP-1:0]              cmp_irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // crystal edge detect
    logic xtal_prev;
    logic next_xtal_prev;
    logic xtal_rise;

    always_comb begin
        next_xtal_prev = xtal_clk_i;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            xtal_prev <= 1'b0;
        end else begin
            xtal_prev <= next_xtal_prev;
        end
    end

    assign xtal_rise = xtal_clk_i & ~xtal_prev;

    // step condition per channel class
    function automatic logic chan_step(input int idx, input logic rise, input logic stopped);
        chan_step = (idx == XTAL_CH) ? rise : ~stopped;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // tick timer channels
    logic [NUM_CH-1:0] expire;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] next_count;
        logic             run;
        logic             next_run;
        logic             irq;
        logic             next_irq;
        logic             trig;
        logic             next_trig;
        logic             step;

        assign step      = chan_step(i, xtal_rise, stop_mode_i);
        assign expire[i] = ch_cfg_i[i].enable & run & step & (count == timers_pkg::CNT_RST);

        always_comb begin
            next_count = count;
            next_run   = ch_cfg_i[i].enable;
            next_irq   = irq & ~ch_ack_i[i];
            next_trig  = 1'b0;
            if (!ch_cfg_i[i].enable || !run) begin
                next_count = ch_load_i[i];
            end else if (step) begin
                if (count == timers_pkg::CNT_RST) begin
                    next_count = ch_load_i[i];
                    if (ch_cfg_i[i].irq_en) begin
                        next_irq = 1'b1;
                    end
                    if (ch_cfg_i[i].trig_en) begin
                        next_trig = 1'b1;
                    end
                end else begin
                    next_count = count - timers_pkg::CNT_ONE;
                end
            end
        end

        always_ff @(posedge clk_sys_i) begin
            if (rst_i) begin
                count <= timers_pkg::CNT_RST;
                run   <= 1'b0;
                irq   <= 1'b0;
                trig  <= 1'b0;
            end else begin
                count <= next_count;
                run   <= next_run;
                irq   <= next_irq;
                trig  <= next_trig;
            end
        end

        // registered state driven to the outputs
        assign ch_irq_o[i]   = irq;
        assign ch_trig_o[i]  = trig;
        assign ch_count_o[i] = count;
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake-up request, held until stop mode is left
    logic restart;
    logic next_restart;

    always_comb begin
        next_restart = stop_mode_i & (restart | expire[XTAL_CH]);
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            restart <= 1'b0;
        end else begin
            restart <= next_restart;
        end
    end

    assign sysclk_restart_o = restart;

    ////////////////////////////////////////////////////////////////////////////
    // task monitor
    task_monitor_timer #(
        .CNT_W   (CNT_W),
        .PRE_W   (timers_pkg::PRE_W),
        .NUM_CMP (NUM_CMP)
    ) u_task_monitor_timer (
        .clk_sys_i    (clk_sys_i),
        .rst_i        (rst_i),
        .cfg_i        (mon_cfg_i),
        .cmp_val_i    (cmp_val_i),
        .cmp_en_i     (cmp_en_i),
        .cmp_ack_i    (cmp_ack_i),
        .debug_mode_i (debug_mode_i),
        .stop_mode_i  (stop_mode_i),
        .count_o      (mon_count_o),
        .cmp_irq_o    (cmp_irq_o)
    );

endmodule

// ---- dv/timers_chk.sv ----
`timescale 1ns/10ps
module timers_chk #(
    parameter int NUM_CH  = timers_pkg::NUM_CH,
    parameter int NUM_CMP = timers_pkg::NUM_CMP,
    parameter int CNT_W   = timers_pkg::CNT_W
) (
    // clock, reset and inputs
    input wire logic                              clk_sys_i,
    input wire logic                              rst_i,
    input wire logic                              stop_mode_i,
    input wire logic                              debug_mode_i,
    input wire timers_pkg::tick_cfg_t [NUM_CH-1:0] ch_cfg_i,
    input wire logic [NUM_CH-1:0][CNT_W-1:0]      ch_load_i,
    input wire logic [NUM_CH-1:0]                 ch_ack_i,
    input wire timers_pkg::monitor_cfg_t          mon_cfg_i,
    input wire logic [NUM_CMP-1:0][CNT_W-1:0]     cmp_val_i,
    input wire logic [NUM_CMP-1:0]                cmp_en_i,
    // outputs
    input wire logic [NUM_CH-1:0]                 ch_irq_o,
    input wire logic [NUM_CH-1:0]                 ch_trig_o,
    input wire logic [NUM_CH-1:0][CNT_W-1:0]      ch_count_o,
    input wire logic                              sysclk_restart_o,
    input wire logic [CNT_W-1:0]                  mon_count_o,
    input wire logic [NUM_CMP-1:0]                cmp_irq_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
        a_irq_sticky: assert property (ch_irq_o[k] && !ch_ack_i[k] |=> ch_irq_o[k])
            else $error("tick flag lost");
        a_trig_cause: assert property (ch_trig_o[k] |-> $past(ch_count_o[k]) == 0)
            else $error("trigger without zero");
        a_idle_load: assert property (!ch_cfg_i[k].enable |=> ch_count_o[k] == $past(ch_load_i[k])
            && !ch_trig_o[k]) else $error("disabled channel not holding load");
    end
    for (genvar k = 0; k < 4; k++) begin : g_sys
        a_count_step: assert property (ch_cfg_i[k].enable && $past(ch_cfg_i[k].enable) && !$past(rst_i)
            |=> ch_count_o[k] == ($past(stop_mode_i) ? $past(ch_count_o[k]) : $past(ch_count_o[k]) == 0
            ? $past(ch_load_i[k]) : $past(ch_count_o[k]) - 1)) else $error("tick count wrong");
        a_fire_event: assert property (ch_cfg_i[k].enable && $past(ch_cfg_i[k].enable) && !$past(rst_i)
            && !stop_mode_i && ch_count_o[k] == 0 |=> ch_trig_o[k] == $past(ch_cfg_i[k].trig_en)
            && (ch_irq_o[k] || !$past(ch_cfg_i[k].irq_en))) else $error("expiry events wrong");
    end
    for (genvar k = 0; k < NUM_CMP; k++) begin : g_cmp
        a_cmp_flag: assert property ($rose(cmp_irq_o[k]) |-> $past(cmp_en_i[k])
            && (mon_count_o - $past(cmp_val_i[k])) inside {32'h1, 32'h2}) else $error("compare flag early");
    end
    a_restart_set: assert property ($rose(sysclk_restart_o) |-> $past(stop_mode_i) && $past(ch_count_o[4]) == 0)
        else $error("restart without expiry");
    a_restart_drop: assert property (!stop_mode_i |=> !sysclk_restart_o)
        else $error("restart held outside stop");
    a_mon_hold: assert property (!mon_cfg_i.enable || stop_mode_i || (debug_mode_i && mon_cfg_i.debug_freeze)
        |=> $stable(mon_count_o)) else $error("monitor moved while held");
    a_mon_step: assert property (mon_count_o != $past(mon_count_o) |-> mon_count_o == $past(mon_count_o) + 1)
        else $error("monitor step not one");
endmodule
bind periodic_and_task_timers timers_chk #(.NUM_CH(NUM_CH), .NUM_CMP(NUM_CMP), .CNT_W(CNT_W)) chk_u (
    .clk_sys_i, .rst_i, .stop_mode_i, .debug_mode_i, .ch_cfg_i, .ch_load_i, .ch_ack_i, .mon_cfg_i,
    .cmp_val_i, .cmp_en_i, .ch_irq_o, .ch_trig_o, .ch_count_o, .sysclk_restart_o, .mon_count_o, .cmp_irq_o);

// ---- dv/test_periodic_and_task_timers.sv ----
`timescale 1ns/10ps
module test_periodic_and_task_timers;
    logic                     clk_sys_i = 1'h0, rst_i = 1'h1, xtal_clk_i = 1'h0;
    logic                     stop_mode_i = 1'h0, debug_mode_i = 1'h0, sysclk_restart_o;
    timers_pkg::tick_cfg_t [4:0] ch_cfg_i = '0;
    timers_pkg::monitor_cfg_t mon_cfg_i = '0;
    logic [4:0][31:0]         ch_load_i = '0, ch_count_o;
    logic [3:0][31:0]         cmp_val_i = '0;
    logic [4:0]               ch_ack_i = '0, ch_irq_o, ch_trig_o, mirq, mtrig, run;
    logic [3:0]               cmp_en_i = '0, cmp_ack_i = '0, cmp_irq_o, mf, mfs;
    logic [31:0]              mon_count_o, mm, mc [5];
    logic [7:0]               mp;
    logic                     mr, xp, step, set, hit;
    int                       errors = 0, checked = 0, cyc = 0;
    integer                   seed = 55;

    periodic_and_task_timers dut_u (.clk_sys_i, .rst_i, .xtal_clk_i, .stop_mode_i, .debug_mode_i, .ch_cfg_i,
        .ch_load_i, .ch_ack_i, .mon_cfg_i, .cmp_val_i, .cmp_en_i, .cmp_ack_i, .ch_irq_o, .ch_trig_o,
        .ch_count_o, .sysclk_restart_o, .mon_count_o, .cmp_irq_o);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            errors++;
            conclude();
        end
    end

    // reference model, stepped on the sampling edge
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            mc = '{default: 32'h0};
            {mirq, mtrig, run, mf, mr, xp, mm, mp} = '0;
        end else begin
            for (int k = 0; k < 5; k++) begin
                set = 1'h0;
                mtrig[k] = 1'h0;
                step = (k < 4) ? !stop_mode_i : xtal_clk_i && !xp;
                if (!run[k] || !ch_cfg_i[k].enable) begin
                    mc[k] = ch_load_i[k];
                end else if (step && mc[k] == 32'h0) begin
                    mc[k] = ch_load_i[k];
                    mtrig[k] = ch_cfg_i[k].trig_en;
                    set = ch_cfg_i[k].irq_en;
                    mr = mr | (k == 4);
                end else if (step) begin
                    mc[k] = mc[k] - 32'h1;
                end
                run[k] = ch_cfg_i[k].enable;
                mirq[k] = set | (mirq[k] & !ch_ack_i[k]);
            end
            mr = mr & stop_mode_i;
            xp = xtal_clk_i;
            hit = mon_cfg_i.enable && !stop_mode_i && !(debug_mode_i && mon_cfg_i.debug_freeze);
            mfs = 4'h0;
            if (!mon_cfg_i.enable) mp = 8'h0;
            else if (hit && mp == mon_cfg_i.prescale) begin
                for (int k = 0; k < 4; k++) mfs[k] = cmp_en_i[k] && mm == cmp_val_i[k];
                mm = mm + 32'h1;
                mp = 8'h0;
            end else if (hit) mp = mp + 8'h1;
            mf = mfs | (mf & ~cmp_ack_i);
        end
    end

    // every result against the model, crystal channel included
    always @(negedge clk_sys_i) begin
        if (!rst_i) begin
            for (int k = 0; k < 5; k++) chk(ch_count_o[k], mc[k]);
            chk(32'(ch_irq_o), 32'(mirq));
            chk(32'(ch_trig_o), 32'(mtrig));
            chk(32'(sysclk_restart_o), 32'(mr));
            chk(mon_count_o, mm);
            chk(32'(cmp_irq_o), 32'(mf));
        end
        ch_ack_i <= 5'($random(seed) & $random(seed));
        cmp_ack_i <= 4'($random(seed) & $random(seed));
        xtal_clk_i <= cyc % 8 >= 4;
    end

    initial begin
        repeat (4) @(negedge clk_sys_i);
        for (int p = 0; p < 24; p++) begin
            rst_i = (p == 12);
            for (int k = 0; k < 5; k++) begin
                ch_cfg_i[k] = {(p + k) % 5 != 4, 2'($random(seed))};
                ch_load_i[k] = 32'($random(seed)) & 32'h1F;
            end
            for (int k = 0; k < 4; k++) cmp_val_i[k] = mm + (32'($random(seed)) & 32'h3F);
            cmp_en_i = 4'($random(seed));
            mon_cfg_i = {p % 4 != 3, 1'($random(seed)), 8'($random(seed)) & 8'h03};
            stop_mode_i = p % 3 == 2;
            debug_mode_i = 1'($random(seed));
            repeat (300) @(negedge clk_sys_i);
        end
        conclude();
    end
endmodule
